// ===== rfb_pkg.sv
// shared constants and types of the receive frame filter and buffer ring
package rfb_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FIRST = 8'h04;
  localparam logic [7:0] OFS_END = 8'h08;
  localparam logic [7:0] OFS_WPTR = 8'h0c;
  localparam logic [7:0] OFS_RPTR = 8'h10;
  localparam logic [7:0] OFS_REL = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_STA_LO = 8'h1c;
  localparam logic [7:0] OFS_STA_HI = 8'h20;
  localparam logic [7:0] OFS_MC_LO = 8'h24;
  localparam logic [7:0] OFS_MC_HI = 8'h28;
  localparam int CTRL_RXEN = 0;
  localparam int CTRL_BCAST = 1;
  localparam int CTRL_MCAST = 2;
  localparam int CTRL_PROMISC = 3;
  localparam int CTRL_ERRACC = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] FIRST_RST = 8'h40;
  localparam logic [7:0] END_RST = 8'h80;
  localparam logic [7:0] WPTR_RST = 8'h41;
  localparam logic [7:0] RPTR_RST = 8'h40;
  localparam logic [47:0] STA_RST = 48'h0;
  localparam logic [63:0] MC_RST = 64'h0;
  localparam logic [7:0] HDR_OFS = 8'h04;
  localparam logic [7:0] PAGE_LAST_OFS = 8'hff;
  localparam logic [15:0] RUNT_MIN = 16'h0040;
  localparam logic [15:0] DA_LAST_IDX = 16'h0005;
  localparam logic [5:0] PRE_BITS = 6'h3e;
  localparam logic [4:0] FCS_LAST = 5'h1f;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
  localparam int STS_OK = 0;
  localparam int STS_CRC = 1;
  localparam int STS_ALIGN = 2;
  localparam int STS_RUNT = 3;
  localparam int STS_GROUP = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_SYNC = 5'h02,
    RX_DATA = 5'h04,
    RX_HEAD = 5'h08,
    RX_DROP = 5'h10
  } rfb_rx_e;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_PRE = 5'h02,
    TX_SFD = 5'h04,
    TX_DATA = 5'h08,
    TX_FCS = 5'h10
  } rfb_tx_e;
endpackage

// ===== rfb_crc_step.sv
// one serial step of the reflected 32-bit frame check register
`timescale 1ns/100ps
`default_nettype none
module rfb_crc_step
  import rfb_pkg::*;
(
  input wire logic [31:0] crc_in,
  input wire logic data_bit,
  output logic [31:0] crc_out
);
  assign crc_out = {1'b0, crc_in[31:1]} ^
                   ((crc_in[0] ^ data_bit) ? CRC_POLY : 32'h0);
endmodule
`default_nettype wire

// ===== rfb_tx_serial.sv
// transmit serializer: preamble, delimiter, data bytes, frame check
`timescale 1ns/100ps
`default_nettype none
module rfb_tx_serial
  import rfb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_fall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_en,
  output logic tx_data
);
  typedef struct packed {
    rfb_tx_e st;
    logic [5:0] cnt;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic last;
    logic [31:0] crc;
    logic en;
    logic dout;
  } rfb_tx_s;

  rfb_tx_s s_r;
  rfb_tx_s s_nxt;
  logic take;
  logic cur_bit;
  logic [31:0] crc_stepped;

  assign take = link_fall && s_r.st == TX_DATA && s_r.bitn == 3'h0;
  assign tx_ready = take && tx_valid;
  assign cur_bit = (s_r.bitn == 3'h0) ? tx_byte[0] : s_r.sh[0];
  assign tx_en = s_r.en;
  assign tx_data = s_r.dout;

  rfb_crc_step u_crc (
    .crc_in(s_r.crc),
    .data_bit(cur_bit),
    .crc_out(crc_stepped)
  );

  always_comb begin
    s_nxt = s_r;
    if (link_fall) begin
      unique case (s_r.st)
        TX_IDLE: begin
          s_nxt.en = 1'b0;
          s_nxt.dout = 1'b0;
          if (tx_valid) begin
            s_nxt.st = TX_PRE;
            s_nxt.en = 1'b1;
            s_nxt.dout = 1'b1;
            s_nxt.cnt = 6'h01;
          end
        end
        TX_PRE: begin
          if (s_r.cnt == PRE_BITS) begin
            s_nxt.st = TX_SFD;
            s_nxt.dout = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt + 6'h01;
            s_nxt.dout = ~s_r.dout;
          end
        end
        TX_SFD: begin
          s_nxt.st = TX_DATA;
          s_nxt.dout = 1'b1;
          s_nxt.bitn = 3'h0;
          s_nxt.crc = CRC_INIT;
        end
        TX_DATA: begin
          if (s_r.bitn == 3'h0 && !tx_valid) begin
            s_nxt.st = TX_FCS;
            s_nxt.cnt = 6'h01;
            s_nxt.dout = ~s_r.crc[0];
            s_nxt.crc = {1'b0, s_r.crc[31:1]};
          end else begin
            s_nxt.dout = cur_bit;
            s_nxt.crc = crc_stepped;
            s_nxt.bitn = s_r.bitn + 3'h1;
            if (s_r.bitn == 3'h0) begin
              s_nxt.sh = {1'b0, tx_byte[7:1]};
              s_nxt.last = tx_last;
            end else begin
              s_nxt.sh = {1'b0, s_r.sh[7:1]};
            end
            if (s_r.bitn == 3'h7 && s_r.last) begin
              s_nxt.st = TX_FCS;
              s_nxt.cnt = 6'h00;
            end
          end
        end
        TX_FCS: begin
          if (s_r.cnt > {1'b0, FCS_LAST}) begin
            s_nxt.st = TX_IDLE;
            s_nxt.en = 1'b0;
            s_nxt.dout = 1'b0;
          end else begin
            s_nxt.dout = ~s_r.crc[0];
            s_nxt.crc = {1'b0, s_r.crc[31:1]};
            s_nxt.cnt = s_r.cnt + 6'h01;
          end
        end
      endcase
      if (s_r.st == TX_DATA && s_r.bitn == 3'h7 && s_r.last) begin
        s_nxt.dout = cur_bit;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= TX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== rfb_top.sv
// receive frame filter with buffer ring writer, axi4-lite registers
// Overview of operation
// - transmit sends 62 alternating one/zero preamble bits before delimiter.
// - receive drops preamble, aligns bytes at first two consecutive ones.
// - address with first bit zero accepted only on full station match or in promiscuous mode.
// - group address hashed to 6 bits selecting one of 64 filter bits.
// - all-ones destination is broadcast, its own acceptance class.
// - broadcast, multicast, promiscuous selectable, physical match always on; promiscuous takes all.
// - source address and length field stored unchanged, never interpreted.
// - transmit computes 32-bit ethernet crc and appends it.
// - receive runs same crc, fixed residue and at least 64 bytes mean good, else reject unless errored frames accepted.
// - frames stored in ring of contiguous 256-byte pages.
// - ring first and end pages are eight-bit software registers.
// - dma address reaching end page reloads with first page.
// - write page pointer marks frame start; dma reloads from it on error.
// - read page pointer marks oldest unread frame, advanced on removal.
// - new frame starts at write page, first four bytes left for header.
// - full page continues into next contiguous page, never skipping.
// - next page equal to end page continues at first page.
// - next page equal to read page aborts reception.
// - group frame other than broadcast accepted only when multicast is enabled and hashed filter bit is set, or in promiscuous mode.
// - good frame gets header, tail skipped, write page advanced.
// - rejected frame pages reclaimed unless errored frames accepted.
`timescale 1ns/100ps
`default_nettype none
module rfb_top
  import rfb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  input wire logic rx_data,
  input wire logic rx_crs,
  output logic tx_en,
  output logic tx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);
  typedef struct packed {
    logic [1:0] clk_s;
    logic [1:0] dat_s;
    logic [1:0] crs_s;
    logic clk_d;
    rfb_rx_e st;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic prev_bit;
    logic [31:0] crc;
    logic [15:0] nbytes;
    logic [15:0] dma;
    logic [47:0] da;
    logic hit;
    logic grp;
    logic [1:0] hidx;
    logic [7:0] status;
    logic [7:0] nextp;
    logic we;
    logic [15:0] waddr;
    logic [7:0] wbyte;
    logic [4:0] ctrl;
    logic [7:0] first;
    logic [7:0] last;
    logic [7:0] wptr;
    logic [7:0] rptr;
    logic [47:0] sta;
    logic [63:0] mc;
    logic [15:0] nrx;
    logic [7:0] last_st;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfb_top_s;

  rfb_top_s st_r;
  rfb_top_s st_nxt;
  logic link_rise;
  logic link_fall;
  logic cur_bit;
  logic crs;
  logic [31:0] crc_stepped;

  assign link_rise = st_r.clk_s[1] && !st_r.clk_d;
  assign link_fall = !st_r.clk_s[1] && st_r.clk_d;
  assign cur_bit = st_r.dat_s[1];
  assign crs = st_r.crs_s[1];

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign mem_we = st_r.we;
  assign mem_addr = st_r.waddr;
  assign mem_wdata = st_r.wbyte;

  rfb_crc_step u_rx_crc (
    .crc_in(st_r.crc),
    .data_bit(cur_bit),
    .crc_out(crc_stepped)
  );

  rfb_tx_serial u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .link_fall(link_fall),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .tx_en(tx_en),
    .tx_data(tx_data)
  );

  function automatic logic [31:0] lane(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // page after p inside the ring
  function automatic logic [7:0] step_page(input logic [7:0] p,
                                           input logic [7:0] first,
                                           input logic [7:0] last);
    logic [7:0] q;
    q = p + 8'h01;
    return (q == last) ? first : q;
  endfunction

  always_comb begin
    logic [31:0] w32;
    logic [7:0] byte_in;
    logic [47:0] da_new;
    logic [7:0] np;
    logic bcast;
    logic phys_ok;
    logic mc_ok;
    logic crc_ok;
    logic runt;
    logic align;
    logic [7:0] sts;
    w32 = 32'h0;
    byte_in = 8'h0;
    da_new = 48'h0;
    np = 8'h0;
    bcast = 1'b0;
    phys_ok = 1'b0;
    mc_ok = 1'b0;
    crc_ok = 1'b0;
    runt = 1'b0;
    align = 1'b0;
    sts = 8'h0;
    st_nxt = st_r;
    st_nxt.clk_s = {st_r.clk_s[0], link_clk};
    st_nxt.dat_s = {st_r.dat_s[0], rx_data};
    st_nxt.crs_s = {st_r.crs_s[0], rx_crs};
    st_nxt.clk_d = st_r.clk_s[1];
    st_nxt.we = 1'b0;

    // register bus, write side
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wd = s_axi_wdata;
      st_nxt.ws = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      unique case ({st_r.awaddr[7:2], 2'h0})
        OFS_CTRL: begin
          w32 = lane({27'h0, st_r.ctrl}, st_r.wd, st_r.ws);
          st_nxt.ctrl = w32[4:0];
        end
        OFS_FIRST: begin
          w32 = lane({24'h0, st_r.first}, st_r.wd, st_r.ws);
          st_nxt.first = w32[7:0];
        end
        OFS_END: begin
          w32 = lane({24'h0, st_r.last}, st_r.wd, st_r.ws);
          st_nxt.last = w32[7:0];
        end
        OFS_WPTR: begin
          w32 = lane({24'h0, st_r.wptr}, st_r.wd, st_r.ws);
          st_nxt.wptr = w32[7:0];
        end
        OFS_RPTR: begin
          w32 = lane({24'h0, st_r.rptr}, st_r.wd, st_r.ws);
          st_nxt.rptr = w32[7:0];
        end
        OFS_REL: begin
          st_nxt.rptr = step_page(st_r.rptr, st_r.first, st_r.last);
        end
        OFS_STA_LO: st_nxt.sta[31:0] = lane(st_r.sta[31:0], st_r.wd, st_r.ws);
        OFS_STA_HI: begin
          w32 = lane({16'h0, st_r.sta[47:32]}, st_r.wd, st_r.ws);
          st_nxt.sta[47:32] = w32[15:0];
        end
        OFS_MC_LO: st_nxt.mc[31:0] = lane(st_r.mc[31:0], st_r.wd, st_r.ws);
        OFS_MC_HI: st_nxt.mc[63:32] = lane(st_r.mc[63:32], st_r.wd, st_r.ws);
        OFS_STAT: st_nxt.bresp = RESP_SLVERR;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // register bus, read side
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'h0})
        OFS_CTRL: st_nxt.rdata = {27'h0, st_r.ctrl};
        OFS_FIRST: st_nxt.rdata = {24'h0, st_r.first};
        OFS_END: st_nxt.rdata = {24'h0, st_r.last};
        OFS_WPTR: st_nxt.rdata = {24'h0, st_r.wptr};
        OFS_RPTR: st_nxt.rdata = {24'h0, st_r.rptr};
        OFS_REL: st_nxt.rdata = 32'h0;
        OFS_STAT: st_nxt.rdata = {st_r.nrx, st_r.last_st, 7'h0,
                                  st_r.st != RX_IDLE};
        OFS_STA_LO: st_nxt.rdata = st_r.sta[31:0];
        OFS_STA_HI: st_nxt.rdata = {16'h0, st_r.sta[47:32]};
        OFS_MC_LO: st_nxt.rdata = st_r.mc[31:0];
        OFS_MC_HI: st_nxt.rdata = st_r.mc[63:32];
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // receive path; hardware updates follow software writes and win
    unique case (st_r.st)
      RX_IDLE: begin
        if (crs && st_r.ctrl[CTRL_RXEN]) begin
          st_nxt.st = RX_SYNC;
          st_nxt.prev_bit = 1'b0;
        end
      end
      RX_SYNC: begin
        if (!crs) begin
          st_nxt.st = RX_IDLE;
        end else if (link_rise) begin
          st_nxt.prev_bit = cur_bit;
          if (cur_bit && st_r.prev_bit) begin
            st_nxt.st = RX_DATA;
            st_nxt.crc = CRC_INIT;
            st_nxt.bitn = 3'h0;
            st_nxt.nbytes = 16'h0;
            st_nxt.hit = 1'b0;
            st_nxt.dma = {st_r.wptr, HDR_OFS};
          end
        end
      end
      RX_DATA: begin
        if (!crs) begin
          crc_ok = st_r.crc == CRC_RESIDUE;
          runt = st_r.nbytes < RUNT_MIN;
          align = st_r.bitn != 3'h0 && !crc_ok;
          sts[STS_OK] = crc_ok && !runt;
          sts[STS_CRC] = !crc_ok && !align;
          sts[STS_ALIGN] = align;
          sts[STS_RUNT] = runt;
          sts[STS_GROUP] = st_r.grp;
          st_nxt.status = sts;
          st_nxt.nextp = (st_r.dma[7:0] == 8'h00) ? st_r.dma[15:8] :
                         step_page(st_r.dma[15:8], st_r.first, st_r.last);
          st_nxt.hidx = 2'h0;
          // rejected frames leave the write page alone
          if (st_r.hit && (sts[STS_OK] || st_r.ctrl[CTRL_ERRACC])) begin
            st_nxt.st = RX_HEAD;
          end else begin
            st_nxt.st = RX_IDLE;
          end
        end else if (link_rise) begin
          st_nxt.crc = crc_stepped;
          st_nxt.sh = {cur_bit, st_r.sh[7:1]};
          st_nxt.bitn = st_r.bitn + 3'h1;
          if (st_r.bitn == 3'h7) begin
            byte_in = {cur_bit, st_r.sh[7:1]};
            // every byte, source and length included, is stored raw
            st_nxt.we = 1'b1;
            st_nxt.waddr = st_r.dma;
            st_nxt.wbyte = byte_in;
            st_nxt.nbytes = st_r.nbytes + 16'h0001;
            st_nxt.dma = st_r.dma + 16'h0001;
            if (st_r.nbytes <= DA_LAST_IDX) begin
              da_new = {byte_in, st_r.da[47:8]};
              st_nxt.da = da_new;
            end
            if (st_r.nbytes == DA_LAST_IDX) begin
              bcast = &da_new;
              phys_ok = !da_new[0] && da_new == st_r.sta;
              mc_ok = da_new[0] && !bcast &&
                      st_r.ctrl[CTRL_MCAST] &&
                      st_r.mc[crc_stepped[31:26]];
              st_nxt.grp = da_new[0];
              st_nxt.hit = st_r.ctrl[CTRL_PROMISC] || phys_ok || mc_ok ||
                           (bcast && st_r.ctrl[CTRL_BCAST]);
              if (!st_nxt.hit) begin
                st_nxt.st = RX_DROP;
              end
            end
            if (st_r.dma[7:0] == PAGE_LAST_OFS) begin
              np = step_page(st_r.dma[15:8], st_r.first,
                             st_r.last);
              st_nxt.dma = {np, 8'h00};
              if (np == st_r.rptr) begin
                st_nxt.st = RX_DROP;
              end
            end
          end
        end
      end
      RX_HEAD: begin
        st_nxt.we = 1'b1;
        st_nxt.waddr = {st_r.wptr, 6'h00, st_r.hidx};
        unique case (st_r.hidx)
          2'h0: st_nxt.wbyte = st_r.status;
          2'h1: st_nxt.wbyte = st_r.nextp;
          2'h2: st_nxt.wbyte = st_r.nbytes[7:0];
          2'h3: st_nxt.wbyte = st_r.nbytes[15:8];
        endcase
        st_nxt.hidx = st_r.hidx + 2'h1;
        if (st_r.hidx == 2'h3) begin
          st_nxt.wptr = st_r.nextp;
          st_nxt.nrx = st_r.nrx + 16'h0001;
          st_nxt.last_st = st_r.status;
          st_nxt.st = RX_IDLE;
        end
      end
      RX_DROP: begin
        if (!crs) begin
          st_nxt.st = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.st <= RX_IDLE;
      st_r.ctrl <= CTRL_RST;
      st_r.first <= FIRST_RST;
      st_r.last <= END_RST;
      st_r.wptr <= WPTR_RST;
      st_r.rptr <= RPTR_RST;
      st_r.sta <= STA_RST;
      st_r.mc <= MC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== rfb_top_sva.sv
// port assertions of the receive filter and buffer ring
`timescale 1ns/100ps
`default_nettype none
module rfb_top_sva
  import rfb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid stayed after bready");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid stayed after rready");
  AST_W_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken in response");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken in response");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_MEM_HOLD: assert property (!mem_we |->
    $stable(mem_addr) && $stable(mem_wdata)) else $error("memory bus moved");
  AST_HDR_SEQ: assert property (mem_we && $past(mem_we) &&
    $past(mem_addr[7:0]) < 8'h03 |-> mem_addr == $past(mem_addr) + 16'h1)
    else $error("header writes out of order");
  AST_TX_PULSE: assert property (tx_ready |-> tx_valid ##1 !tx_ready)
    else $error("transmit take without offer");
  COV_HDR: cover property (mem_we ##1 mem_we ##1 mem_we ##1 mem_we);
  COV_TX: cover property (tx_valid && tx_ready);
  COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind rfb_top rfb_top_sva rfb_top_sva_i(.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .tx_valid, .tx_ready, .mem_we, .mem_addr, .mem_wdata);
`default_nettype wire

// ===== rfb_codec.sv
// line codec model: nrz receive frames with clock, clock for transmit
`timescale 1ns/100ps
`default_nettype none
module rfb_codec
  import rfb_pkg::*;
(
  output logic link_clk,
  output logic rx_data,
  output logic rx_crs
);
  logic [7:0] fb [$];
  initial begin
    link_clk = 1'h0;
    rx_data = 1'h0;
    rx_crs = 1'h0;
  end
  function automatic logic [31:0] crc_f(input logic [31:0] c,
                                        input logic [7:0] b);
    for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ b[j]) ? CRC_POLY : 0);
    return c;
  endfunction
  // clock only while bits are due, still otherwise
  task clk_run(input int n);
    repeat (n) begin
      #160 link_clk = 1'h1;
      #160 link_clk = 1'h0;
    end
  endtask
  task bit_out(input logic b);
    rx_data = b;
    clk_run(1);
  endtask
  task send(input bit bad);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (fb[i]) c = crc_f(c, fb[i]);
    c = ~c ^ 32'(bad);
    for (int i = 0; i < 4; i++) fb.push_back(c[8*i+:8]);
    rx_crs = 1'h1; // shortened preamble, then two-bit delimiter
    repeat (10) begin
      bit_out(1'h1);
      bit_out(1'h0);
    end
    bit_out(1'h1);
    bit_out(1'h1);
    foreach (fb[i]) for (int j = 0; j < 8; j++) bit_out(fb[i][j]);
    #320 rx_crs = 1'h0;
    rx_data = ~rx_data;
  endtask
endmodule
`default_nettype wire

// ===== rfb_top_test.sv
// self-checking bench of the receive filter and buffer ring
`timescale 1ns/100ps
`default_nettype none
module rfb_top_test;
  import rfb_pkg::*;
  localparam logic [47:0] STA = 48'h554433221102;
  localparam logic [47:0] MIS = 48'h564433221102;
  localparam logic [47:0] MCA = 48'h554433221101;
  localparam logic [47:0] BCA = 48'hffffffffffff;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, tx_valid = 1'h0, tx_last = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, tx_byte = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, rx_crs;
  logic s_axi_rvalid, tx_en, tx_data, tx_ready, mem_we, link_clk, rx_data;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem [logic [15:0]];
  logic txq [$];
  int n_fail = 0, n_tests = 0, cyc = 0;
  rfb_top rfb_top_i(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_clk, .rx_data, .rx_crs, .tx_en,
    .tx_data, .tx_valid, .tx_byte, .tx_last, .tx_ready, .mem_we, .mem_addr,
    .mem_wdata);
  rfb_codec rfb_codec_i(.link_clk, .rx_data, .rx_crs);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (mem_we === 1'h1) mem[mem_addr] = mem_wdata;
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      end_sim();
    end
  end
  always @(posedge link_clk) if (tx_en === 1'h1) txq.push_back(tx_data);
  task end_sim;
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [127:0] s, input logic [127:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, b;
    b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready === 1'h1;
      w = s_axi_wvalid && s_axi_wready === 1'h1;
      b = s_axi_bvalid === 1'h1;
      last_resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    bit ar, r;
    r = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready === 1'h1;
      r = s_axi_rvalid === 1'h1;
      d = s_axi_rdata;
      last_resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (r) s_axi_rready <= 1'h0;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("register", d, e);
  endtask
  // one frame in, then header, data and write page judged
  task rx(input logic [47:0] da, input int n, input bit bad,
          input logic [7:0] pg, input logic [7:0] st, input logic [7:0] nx);
    logic [31:0] d;
    int k;
    mem.delete();
    rfb_codec_i.fb.delete();
    for (k = 0; k < n - 4; k++)
      rfb_codec_i.fb.push_back(k < 6 ? da[8*k+:8] : 8'(k) ^ 8'h5a);
    rfb_codec_i.send(bad);
    for (k = 0; k < 60 && !mem.exists({pg, 8'h03}); k++) @(negedge aclk);
    rd(OFS_WPTR, d);
    if (st !== 8'h0) begin
      chk("status", mem[{pg, 8'h00}], st);
      chk("next page", mem[{pg, 8'h01}], nx);
      chk("count", {mem[{pg, 8'h03}], mem[{pg, 8'h02}]}, 16'(n));
      for (k = 0; k < 16; k++)
        chk("data", mem[{pg, 8'h04} + 16'(k)], rfb_codec_i.fb[k]);
      chk("write page", d, 32'(nx));
    end else begin
      chk("header", mem.exists({pg, 8'h00}), 1'h0);
      chk("write page", d, 32'(pg));
    end
  endtask
  task t_regs;
    rdchk(OFS_FIRST, 32'(FIRST_RST));
    rdchk(OFS_END, 32'(END_RST));
    rdchk(OFS_WPTR, 32'(WPTR_RST));
    rdchk(OFS_RPTR, 32'(RPTR_RST));
    wr(8'h3c, 32'h0);
    chk("unmapped", last_resp, RESP_SLVERR);
    rdchk(8'h3c, 32'h0);
    chk("unmapped", last_resp, RESP_SLVERR);
    wr(OFS_END, 32'h43);
    rdchk(OFS_END, 32'h43);
    wr(OFS_STA_LO, STA[31:0]);
    wr(OFS_STA_HI, 32'(STA[47:32]));
    wr(OFS_CTRL, 32'h1);
  endtask
  task t_phys;
    rx(STA, 64, 0, 8'h41, 8'h01, 8'h42);
    rx(STA, 64, 1, 8'h42, 8'h00, 8'h00);
    rx(MIS, 64, 0, 8'h42, 8'h00, 8'h00);
  endtask
  task t_filt;
    rx(BCA, 64, 0, 8'h42, 8'h00, 8'h00);
    wr(OFS_CTRL, 32'h3);
    rx(BCA, 64, 0, 8'h42, 8'h21, 8'h40);
    wr(OFS_REL, 32'h0);
    rdchk(OFS_RPTR, 32'h41);
    wr(OFS_CTRL, 32'h5);
    rx(MCA, 64, 0, 8'h40, 8'h00, 8'h00);
    wr(OFS_MC_LO, 32'hffffffff);
    wr(OFS_MC_HI, 32'hffffffff);
    rx(MCA, 64, 0, 8'h40, 8'h21, 8'h41);
    wr(OFS_CTRL, 32'h9);
    rx(MIS, 64, 0, 8'h41, 8'h01, 8'h42);
  endtask
  task t_ring;
    rx(STA, 260, 0, 8'h42, 8'h01, 8'h41);
    chk("linked", mem[16'h4000], rfb_codec_i.fb[252]);
    chk("end page", mem.exists(16'h4300), 1'h0);
    wr(OFS_WPTR, 32'h42);
    wr(OFS_RPTR, 32'h40);
    rx(STA, 260, 0, 8'h42, 8'h00, 8'h00);
    chk("overwrite", mem.exists(16'h4000), 1'h0);
  endtask
  task t_tx;
    logic [103:0] e, s;
    int k;
    e[103:72] = ~rfb_codec_i.crc_f(CRC_INIT, 8'ha5);
    e[71:62] = {8'ha5, 2'h3};
    for (k = 0; k < 62; k++) e[k] = ~k[0];
    txq.delete();
    @(posedge aclk);
    tx_byte <= 8'ha5;
    tx_last <= 1'h1;
    tx_valid <= 1'h1;
    fork
      rfb_codec_i.clk_run(112);
      begin
        for (k = 0; k < 20000 && tx_ready !== 1'h1; k++) @(negedge aclk);
        @(posedge aclk);
        tx_valid <= 1'h0;
      end
    join
    for (k = 0; k < 104; k++) s[k] = txq[k];
    chk("tx length", 32'(txq.size()), 32'd104);
    chk("tx bits", s, e);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_phys();
    t_filt();
    t_ring();
    t_tx();
    end_sim();
  end
endmodule
`default_nettype wire
